/* core/ivp_pkg.sv */
// Constants, types and register map of the interrupt vector and priority block
// Summary of operation
// R1 - Pending sources resolve in fixed listed order
// R2 - Clock monitor reset, enabled by monitor bits
// R3 - Eight timer channels, I-masked, per-channel enables
// R4 - Timer overflow I-masked, gated, elevatable
// R5 - Accumulator overflow gated by its enable bit
// R6 - Accumulator edge gated by its enable bit
// R7 - Modulus underflow gated, lowest listed source
// R8 - Elevation value promotes one maskable source
// R9 - Request bus is 56 lines wide
// R10 - Reset forces defined states, RAM untouched
// R11 - EEPROM map resets 0x01, written once in normal modes
// R12 - Program page writable always, resets zero
// R13 - Present winning vector; non-maskables always win
package ivp_pkg;

  // ==========================================
  // Request bus and vector layout
  localparam int NUM_REQ = 56;
  localparam int IDX_W = 6;
  localparam logic [7:0] VEC_HIGH = 8'hFF;
  localparam logic [7:0] VEC_TOP = 8'hFE;
  localparam logic [7:0] VEC_LOWEST = 8'h90;
  localparam logic [7:0] ELEV_HIGHEST = 8'hF2;
  localparam logic [IDX_W-1:0] IDX_RESET = 6'h00;
  localparam logic [IDX_W-1:0] IDX_CLKMON = 6'h01;
  localparam logic [IDX_W-1:0] IDX_WDOG = 6'h02;
  localparam logic [IDX_W-1:0] IDX_XREQ = 6'h05;
  localparam logic [IDX_W-1:0] IDX_EXTREQ = 6'h06;
  localparam logic [IDX_W-1:0] IDX_TCH0 = 6'h08;
  localparam logic [IDX_W-1:0] IDX_TCH7 = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_TOVF = 6'h10;
  localparam logic [IDX_W-1:0] IDX_PAOVF = 6'h11;
  localparam logic [IDX_W-1:0] IDX_PAEDGE = 6'h12;
  localparam logic [IDX_W-1:0] IDX_MODZ = 6'h1A;
  localparam logic [IDX_W-1:0] IDX_FIRST_I = 6'h06;

  // ==========================================
  // Register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_ELEV = 8'h00;
  localparam logic [7:0] A_PLL = 8'h04;
  localparam logic [7:0] A_TCHIE = 8'h08;
  localparam logic [7:0] A_TIMER_SYSTEM_REG_TWO = 8'h0C;
  localparam logic [7:0] A_PULSE_ACC_CONTROL = 8'h10;
  localparam logic [7:0] A_MODULUS_COUNTER_CONTROL = 8'h14;
  localparam logic [7:0] A_EXTCTL = 8'h18;
  localparam logic [7:0] A_EEMAP = 8'h1C;
  localparam logic [7:0] A_PROGRAM_PAGE_REG = 8'h20;
  localparam logic [7:0] A_COP = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;
  localparam logic [7:0] A_PEND_LO = 8'h2C;
  localparam logic [7:0] A_PEND_HI = 8'h30;

  // ==========================================
  // Field positions and reset values
  localparam int B_CME = 0;
  localparam int B_SELF_CLOCK_MODE_ENABLE = 1;
  localparam int B_TOVIE = 7;
  localparam int B_PULSE_ACC_OVERFLOW_IE = 1;
  localparam int B_PAI = 0;
  localparam int B_MODULUS_ZERO_IE = 7;
  localparam int B_EXTEN = 6;
  localparam logic [7:0] RST_ELEV = 8'hF2;
  localparam logic [7:0] RST_PLL = 8'h03;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_EXTCTL = 8'h40;
  localparam logic [7:0] RST_EEMAP = 8'h01;
  localparam logic [7:0] RST_PROGRAM_PAGE_REG = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } ivp_wr_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } ivp_vec_t;

endpackage : ivp_pkg

/* core/ivp_prio_find.sv */
// Fixed-order search: lowest set request index wins
`timescale 1ns/10ps
module ivp_prio_find #(
  parameter int N = 56,
  parameter int IW = 6
) (
  // Requests, index 0 highest
  input wire logic [N-1:0] req,
  // Result
  output logic found,
  output logic [IW-1:0] idx
);

  initial begin
    if (N < 1 || N > (1 << IW)) $error("ivp_prio_find: N does not fit IW");
  end

  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1; // R1
        idx = IW'(i);
      end
    end
  end

endmodule : ivp_prio_find

/* core/ivp_axil_port.sv */
// AXI4-Lite slave handshake front end for the register file
`timescale 1ns/10ps
module ivp_axil_port #(
  parameter int AW = 8
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  // Write channels
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register file side
  input wire logic [31:0] rdData,
  input wire logic rdErr,
  input wire logic wrErr,
  output logic wrStb,
  output ivp_pkg::ivp_wr_t wrReq
);

  logic awHeld_ff;
  logic wHeld_ff;
  wire awTake = awvalid && awready;
  wire wTake = wvalid && wready;
  wire doWrite = awHeld_ff && wHeld_ff && !bvalid;
  wire arTake = arvalid && arready;

  assign awready = !awHeld_ff && !bvalid;
  assign wready = !wHeld_ff && !bvalid;
  assign arready = !rvalid;
  assign wrStb = doWrite && clkEn;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      bvalid <= 1'b0;
      bresp <= ivp_pkg::RESP_OKAY;
      wrReq <= '0;
    end else if (clkEn) begin
      if (awTake) wrReq.addr <= awaddr;
      if (wTake) begin
        wrReq.data <= wdata;
        wrReq.strb <= wstrb;
      end
      awHeld_ff <= doWrite ? 1'b0 : (awHeld_ff || awTake);
      wHeld_ff <= doWrite ? 1'b0 : (wHeld_ff || wTake);
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= wrErr ? ivp_pkg::RESP_SLVERR : ivp_pkg::RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= ivp_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (arTake) begin
        rvalid <= 1'b1;
        rdata <= rdData;
        rresp <= rdErr ? ivp_pkg::RESP_SLVERR : ivp_pkg::RESP_OKAY;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule : ivp_axil_port

/* core/ivp_top.sv */
// Interrupt vector selection, priority elevation and start-up registers
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
module ivp_top #(
  parameter int REQ_W = ivp_pkg::NUM_REQ
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  // AXI4-Lite write address
  input wire logic [ivp_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // AXI4-Lite write data and response
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [ivp_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Request bus and core condition codes
  input wire logic [REQ_W-1:0] reqBus,
  input wire logic ccrIMask,
  input wire logic ccrXMask,
  input wire logic normalMode,
  // Vector to the core
  output logic vectorValid,
  output logic [15:0] vectorAddr,
  // Start-up configuration outputs
  output logic [7:0] eepromMap,
  output logic [7:0] progPage,
  output logic clkMonArmed
);

  // ==========================================
  // Parameter check
  initial begin
    if (REQ_W != ivp_pkg::NUM_REQ) $error("ivp_top: request bus must be 56 lines"); // R9
  end

  // ==========================================
  // Registers
  logic [7:0] priority_elevation_reg_ff;
  logic [7:0] pll_control_reg_ff;
  logic [7:0] timerChanIe_ff;
  logic [7:0] timer_system_reg_two_ff;
  logic [7:0] pulse_acc_control_ff;
  logic [7:0] modulus_counter_control_ff;
  logic [7:0] ext_request_control_ff;
  logic [7:0] eeprom_map_reg_ff;
  logic [7:0] program_page_reg_ff;
  logic [7:0] copRate_ff;
  logic eeWritten_ff;
  ivp_pkg::ivp_vec_t vec_ff;

  // ==========================================
  // Bus front end
  logic wrStb;
  ivp_pkg::ivp_wr_t wrReq;
  logic [31:0] rdData;
  logic rdErr;
  logic wrErr;

  ivp_axil_port #(
    .AW(ivp_pkg::ADDR_W)
  ) u_port (
    .mclk(mclk),
    .reset(reset),
    .clkEn(clkEn),
    .awaddr(s_awaddr),
    .awvalid(s_awvalid),
    .awready(s_awready),
    .wdata(s_wdata),
    .wstrb(s_wstrb),
    .wvalid(s_wvalid),
    .wready(s_wready),
    .bresp(s_bresp),
    .bvalid(s_bvalid),
    .bready(s_bready),
    .arvalid(s_arvalid),
    .arready(s_arready),
    .rdata(s_rdata),
    .rresp(s_rresp),
    .rvalid(s_rvalid),
    .rready(s_rready),
    .rdData(rdData),
    .rdErr(rdErr),
    .wrErr(wrErr),
    .wrStb(wrStb),
    .wrReq(wrReq)
  );

  // ==========================================
  // Address decode
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a <= ivp_pkg::A_PEND_HI) && (a[1:0] == 2'b00);
  endfunction : isMapped

  wire wrLane0 = wrStb && wrReq.strb[0];
  wire [7:0] wByte = wrReq.data[7:0];
  wire wrElev = wrLane0 && (wrReq.addr == ivp_pkg::A_ELEV);
  wire wrPll = wrLane0 && (wrReq.addr == ivp_pkg::A_PLL);
  wire wrTch = wrLane0 && (wrReq.addr == ivp_pkg::A_TCHIE);
  wire wrTsr = wrLane0 && (wrReq.addr == ivp_pkg::A_TIMER_SYSTEM_REG_TWO);
  wire wrPac = wrLane0 && (wrReq.addr == ivp_pkg::A_PULSE_ACC_CONTROL);
  wire wrMcc = wrLane0 && (wrReq.addr == ivp_pkg::A_MODULUS_COUNTER_CONTROL);
  wire wrExt = wrLane0 && (wrReq.addr == ivp_pkg::A_EXTCTL);
  wire wrEeAny = wrLane0 && (wrReq.addr == ivp_pkg::A_EEMAP);
  wire wrEe = wrEeAny && (!normalMode || !eeWritten_ff); // R11
  wire wrPpg = wrLane0 && (wrReq.addr == ivp_pkg::A_PROGRAM_PAGE_REG); // R12
  wire wrCop = wrLane0 && (wrReq.addr == ivp_pkg::A_COP);

  assign wrErr = !isMapped(wrReq.addr);
  assign rdErr = !isMapped(s_araddr);

  // ==========================================
  // Register writes
  // Every control bit has a constant start-up state; no memory is cleared
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      priority_elevation_reg_ff <= ivp_pkg::RST_ELEV; // R10
      pll_control_reg_ff <= ivp_pkg::RST_PLL;
      timerChanIe_ff <= ivp_pkg::RST_ZERO;
      timer_system_reg_two_ff <= ivp_pkg::RST_ZERO;
      pulse_acc_control_ff <= ivp_pkg::RST_ZERO;
      modulus_counter_control_ff <= ivp_pkg::RST_ZERO;
      ext_request_control_ff <= ivp_pkg::RST_EXTCTL;
      copRate_ff <= ivp_pkg::RST_ZERO;
    end else if (clkEn) begin
      if (wrElev) priority_elevation_reg_ff <= {wByte[7:1], 1'b0}; // R8
      if (wrPll) pll_control_reg_ff <= wByte;
      if (wrTch) timerChanIe_ff <= wByte;
      if (wrTsr) timer_system_reg_two_ff <= wByte;
      if (wrPac) pulse_acc_control_ff <= wByte;
      if (wrMcc) modulus_counter_control_ff <= wByte;
      if (wrExt) ext_request_control_ff <= wByte;
      if (wrCop) copRate_ff <= wByte;
    end
  end

  // Write-once lock covers normal modes only; special modes stay open
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      eeprom_map_reg_ff <= ivp_pkg::RST_EEMAP; // R11
      eeWritten_ff <= 1'b0;
      program_page_reg_ff <= ivp_pkg::RST_PROGRAM_PAGE_REG; // R12
    end else if (clkEn) begin
      if (wrEe) eeprom_map_reg_ff <= wByte; // R11
      if (wrEeAny) eeWritten_ff <= 1'b1;
      if (wrPpg) program_page_reg_ff <= wByte; // R12
    end
  end

  // ==========================================
  // Local enables per request line
  // Lines without a local enable here are gated inside their peripheral
  logic [REQ_W-1:0] localEn;
  logic [REQ_W-1:0] ccrOpen;

  function automatic logic srcEnable(input int k, input logic [7:0] tch, input logic [7:0] pll,
                                     input logic [7:0] tsr, input logic [7:0] pac,
                                     input logic [7:0] mcc, input logic [7:0] ext,
                                     input logic [7:0] cop);
    logic en;
    en = 1'b1;
    if (k == int'(ivp_pkg::IDX_CLKMON))
      en = pll[ivp_pkg::B_CME] || pll[ivp_pkg::B_SELF_CLOCK_MODE_ENABLE]; // R2
    else if (k == int'(ivp_pkg::IDX_WDOG))
      en = |cop;
    else if (k == int'(ivp_pkg::IDX_EXTREQ))
      en = ext[ivp_pkg::B_EXTEN];
    else if (k >= int'(ivp_pkg::IDX_TCH0) && k <= int'(ivp_pkg::IDX_TCH7))
      en = tch[k - int'(ivp_pkg::IDX_TCH0)]; // R3
    else if (k == int'(ivp_pkg::IDX_TOVF))
      en = tsr[ivp_pkg::B_TOVIE]; // R4
    else if (k == int'(ivp_pkg::IDX_PAOVF))
      en = pac[ivp_pkg::B_PULSE_ACC_OVERFLOW_IE]; // R5
    else if (k == int'(ivp_pkg::IDX_PAEDGE))
      en = pac[ivp_pkg::B_PAI]; // R6
    else if (k == int'(ivp_pkg::IDX_MODZ))
      en = mcc[ivp_pkg::B_MODULUS_ZERO_IE]; // R7
    srcEnable = en;
  endfunction : srcEnable

  for (genvar k = 0; k < REQ_W; k++) begin : g_qual
    assign localEn[k] = srcEnable(k, timerChanIe_ff, pll_control_reg_ff,
                                  timer_system_reg_two_ff, pulse_acc_control_ff,
                                  modulus_counter_control_ff, ext_request_control_ff,
                                  copRate_ff);
    if (k < int'(ivp_pkg::IDX_XREQ)) begin : g_nmi
      assign ccrOpen[k] = 1'b1; // R13
    end else if (k == int'(ivp_pkg::IDX_XREQ)) begin : g_xmask
      assign ccrOpen[k] = !ccrXMask;
    end else begin : g_imask
      assign ccrOpen[k] = !ccrIMask; // R3
    end
  end

  wire [REQ_W-1:0] qualified = reqBus & localEn & ccrOpen; // R13

  // ==========================================
  // Fixed-order search
  logic baseFound;
  logic [ivp_pkg::IDX_W-1:0] baseIdx;

  ivp_prio_find #(
    .N(REQ_W),
    .IW(ivp_pkg::IDX_W)
  ) u_find (
    .req(qualified),
    .found(baseFound),
    .idx(baseIdx)
  );

  // ==========================================
  // Elevation: promote one I-masked source above the other I-masked ones
  wire [7:0] elev = priority_elevation_reg_ff;
  wire elevInRange = (elev >= ivp_pkg::VEC_LOWEST) && (elev <= ivp_pkg::ELEV_HIGHEST);
  wire [7:0] elevDist = 8'(ivp_pkg::VEC_TOP - elev);
  wire [ivp_pkg::IDX_W-1:0] elevIdx = elevDist[ivp_pkg::IDX_W:1];
  wire elevHit = elevInRange && qualified[elevIdx]; // R8
  // Resets, traps and XIRQ sit below the first I-masked index and are never overtaken
  wire baseIsMaskable = baseIdx >= ivp_pkg::IDX_FIRST_I; // R13
  wire useElev = baseFound && baseIsMaskable && elevHit; // R8
  wire [ivp_pkg::IDX_W-1:0] winIdx = useElev ? elevIdx : baseIdx; // R1

  function automatic logic [7:0] vecLow(input logic [ivp_pkg::IDX_W-1:0] i);
    vecLow = 8'(ivp_pkg::VEC_TOP - 8'({i, 1'b0}));
  endfunction : vecLow

  ivp_pkg::ivp_vec_t nxt_vec;
  assign nxt_vec.valid = baseFound;
  assign nxt_vec.addr = baseFound ? {ivp_pkg::VEC_HIGH, vecLow(winIdx)} : 16'h0000; // R13

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      vec_ff <= '0;
    end else if (clkEn) begin
      vec_ff <= nxt_vec; // R13
    end
  end

  // ==========================================
  // Read mux
  wire [7:0] ra = s_araddr;
  wire [31:0] pend64Lo = qualified[31:0];
  wire [31:0] pend64Hi = 32'(qualified[REQ_W-1:32]);

  assign rdData =
    (ra == ivp_pkg::A_ELEV) ? {24'h0, priority_elevation_reg_ff} :
    (ra == ivp_pkg::A_PLL) ? {24'h0, pll_control_reg_ff} :
    (ra == ivp_pkg::A_TCHIE) ? {24'h0, timerChanIe_ff} :
    (ra == ivp_pkg::A_TIMER_SYSTEM_REG_TWO) ? {24'h0, timer_system_reg_two_ff} :
    (ra == ivp_pkg::A_PULSE_ACC_CONTROL) ? {24'h0, pulse_acc_control_ff} :
    (ra == ivp_pkg::A_MODULUS_COUNTER_CONTROL) ? {24'h0, modulus_counter_control_ff} :
    (ra == ivp_pkg::A_EXTCTL) ? {24'h0, ext_request_control_ff} :
    (ra == ivp_pkg::A_EEMAP) ? {24'h0, eeprom_map_reg_ff} :
    (ra == ivp_pkg::A_PROGRAM_PAGE_REG) ? {24'h0, program_page_reg_ff} :
    (ra == ivp_pkg::A_COP) ? {24'h0, copRate_ff} :
    (ra == ivp_pkg::A_STAT) ? {15'h0, vec_ff.valid, vec_ff.addr} :
    (ra == ivp_pkg::A_PEND_LO) ? pend64Lo :
    (ra == ivp_pkg::A_PEND_HI) ? pend64Hi :
    32'h0000_0000;

  // ==========================================
  // Outputs, all from flip-flops
  assign vectorValid = vec_ff.valid;
  assign vectorAddr = vec_ff.addr;
  assign eepromMap = eeprom_map_reg_ff;
  assign progPage = program_page_reg_ff;

  // Registered so the pin does not ripple from the write decode
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      clkMonArmed <= 1'b0;
    end else if (clkEn) begin
      clkMonArmed <= pll_control_reg_ff[ivp_pkg::B_CME] || pll_control_reg_ff[ivp_pkg::B_SELF_CLOCK_MODE_ENABLE]; // R2
    end
  end

endmodule : ivp_top

/* tb/ivp_chk.sv */
// Port-level property checks for the vector and priority top
`timescale 1ns/10ps
module ivp_chk #(
  parameter int REQ_W = 56
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  // Requests, masks, mode
  input wire logic [REQ_W-1:0] reqBus,
  input wire logic ccrIMask,
  input wire logic ccrXMask,
  input wire logic normalMode,
  // Observed outputs
  input wire logic vectorValid,
  input wire logic [15:0] vectorAddr,
  input wire logic [7:0] eepromMap,
  input wire logic [7:0] progPage,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ======
  // Map change tracker
  logic seenChg_ff;
  logic [7:0] mapPrev_ff;
  logic nxt_seenChg;
  assign nxt_seenChg = seenChg_ff | (mapPrev_ff != eepromMap);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      seenChg_ff <= 1'b0;
      mapPrev_ff <= 8'h01;
    end else begin
      seenChg_ff <= nxt_seenChg;
      mapPrev_ff <= eepromMap;
    end
  end

  // ======
  // Properties
  a_reset_top: assert property (clkEn && reqBus[0] |=> vectorValid && vectorAddr == 16'hFFFE)
    else $error("reset request did not take the top vector");
  a_idle_zero: assert property (clkEn && reqBus == '0 |=> !vectorValid && vectorAddr == 16'h0000)
    else $error("vector shown with no request");
  a_swi_wins: assert property (clkEn && reqBus[3:0] == 4'h0 && reqBus[4] |=> vectorAddr == 16'hFFF6)
    else $error("unmaskable software line lost");
  a_x_line: assert property (clkEn && reqBus[4:0] == 5'h00 && reqBus[5] && !ccrXMask |=> vectorAddr == 16'hFFF4)
    else $error("X line not presented");
  a_i_masked: assert property (clkEn && reqBus[5:0] == 6'h00 && ccrIMask |=> !vectorValid)
    else $error("I-masked line got through");
  a_vec_range: assert property (vectorValid |-> vectorAddr >= 16'hFF90 && !vectorAddr[0])
    else $error("vector outside the request bus range");
  a_map_start: assert property ($fell(reset) |-> eepromMap == 8'h01)
    else $error("map start value wrong");
  a_page_start: assert property ($fell(reset) |-> progPage == 8'h00 && !vectorValid)
    else $error("page or vector start value wrong");
  a_eemap_once: assert property (seenChg_ff && normalMode && clkEn |=> $stable(eepromMap))
    else $error("map changed twice in normal mode");

  c_chan0: cover property (clkEn && reqBus[8] ##1 vectorAddr == 16'hFFEE);
  c_clkmon: cover property (vectorValid && vectorAddr == 16'hFFFC);
  c_slverr: cover property (s_bvalid && s_bresp == 2'b10);
endmodule : ivp_chk

/* tb/ivp_core_model.sv */
// Processor core stand-in: holds the mask bits and takes vectors
`timescale 1ns/10ps
module ivp_core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Mask commands
  input wire logic iCmd,
  input wire logic xCmd,
  // Vector from the block
  input wire logic vectorValid,
  input wire logic [15:0] vectorAddr,
  // Masks and last vector taken
  output logic ccrIMask,
  output logic ccrXMask,
  output logic [15:0] takenVec
);
  // Masks come up set, as a core leaves reset with interrupts off
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ccrIMask <= 1'b1;
      ccrXMask <= 1'b1;
      takenVec <= 16'h0000;
    end else begin
      ccrIMask <= iCmd;
      ccrXMask <= xCmd;
      if (vectorValid) begin
        takenVec <= vectorAddr;
      end
    end
  end
endmodule : ivp_core_model

/* tb/ivp_top_tb.sv */
// Self-checking bench for the vector and priority block
`timescale 1ns/10ps
module ivp_top_tb;
  // ======
  // Signals
  logic mclk, reset, clkEn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, ccrIMask, ccrXMask, normalMode;
  logic vectorValid, clkMonArmed, iCmd, xCmd, lock;
  logic [7:0] s_awaddr, s_araddr, eepromMap, progPage;
  logic [31:0] s_wdata, s_rdata, rdv, seed;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic [55:0] reqBus, rq;
  logic [15:0] vectorAddr, takenVec;
  logic [7:0] rg [0:12];
  int n_errors, n_checks;
  localparam int SL [5] = '{1, 16, 17, 18, 26};
  localparam int SR [5] = '{1, 3, 4, 4, 5};
  localparam int SB [5] = '{0, 7, 1, 0, 7};
  localparam int WREG [9] = '{0, 1, 2, 3, 4, 5, 6, 8, 9};

  ivp_top ivp_top_i (.mclk(mclk), .reset(reset), .clkEn(clkEn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .reqBus(reqBus), .ccrIMask(ccrIMask), .ccrXMask(ccrXMask), .normalMode(normalMode),
    .vectorValid(vectorValid), .vectorAddr(vectorAddr), .eepromMap(eepromMap), .progPage(progPage),
    .clkMonArmed(clkMonArmed));
  ivp_core_model ivp_core_model_i (.mclk(mclk), .reset(reset), .iCmd(iCmd), .xCmd(xCmd),
    .vectorValid(vectorValid), .vectorAddr(vectorAddr), .ccrIMask(ccrIMask), .ccrXMask(ccrXMask),
    .takenVec(takenVec));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ======
  // Reference model
  function automatic logic [31:0] rnd();
    repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic bit mapd(input logic [7:0] a);
    return a <= 8'h30 && a[1:0] == 2'b00;
  endfunction : mapd

  function automatic logic [15:0] exp_vec();
    int w;
    int e;
    bit q [56];
    w = -1;
    e = (254 - int'(rg[0])) / 2;
    for (int k = 0; k < 56; k++) begin
      q[k] = reqBus[k] && !(k == 5 && ccrXMask) && !(k > 5 && ccrIMask);
      case (k)
        1: q[k] &= rg[1][1:0] != 2'b00;
        2: q[k] &= rg[9] != 8'h00;
        6: q[k] &= rg[6][6];
        16: q[k] &= rg[3][7];
        17: q[k] &= rg[4][1];
        18: q[k] &= rg[4][0];
        26: q[k] &= rg[5][7];
        default: q[k] &= k < 8 || k > 15 || rg[2][k-8];
      endcase
      if (q[k] && w < 0) w = k;
    end
    // Elevation only beats maskable winners
    if (rg[0] >= 8'h90 && rg[0] <= 8'hF2 && w >= 6 && q[e]) w = e;
    return (w < 0) ? 16'h0000 : {8'hFF, 8'(254 - 2 * w)};
  endfunction : exp_vec

  task automatic shadow_reset();
    rg = '{8'hF2, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    lock = 1'b0;
  endtask : shadow_reset

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // ======
  // Bus master
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, b;
    @(posedge mclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(negedge mclk);
      ta = s_awready;
      tw = s_wready;
      b = s_bvalid;
      rsp = s_bresp;
      @(posedge mclk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
    end while (!b);
    s_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    bit t;
    @(posedge mclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(negedge mclk);
      t = s_arready;
      @(posedge mclk);
    end while (!t);
    s_arvalid <= 1'b0;
    do begin
      @(negedge mclk);
      t = s_rvalid;
      rdv = s_rdata;
      rsp = s_rresp;
      @(posedge mclk);
    end while (!t);
    s_rready <= 1'b0;
  endtask : axr

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    i = a / 4;
    axw(a, d);
    chk("bresp", mapd(a) ? 2'b00 : 2'b10, rsp);
    if (mapd(a) && i != 7) rg[i] = (i == 0) ? (d[7:0] & 8'hFE) : d[7:0];
    if (mapd(a) && i == 7 && (!lock || !normalMode)) rg[7] = d[7:0];
    if (mapd(a) && i == 7) lock = 1'b1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic [31:0] e;
    logic [15:0] v;
    v = exp_vec();
    e = (a == 8'h28) ? {15'h0, v != 16'h0, v} : ((a < 8'h28) ? {24'h0, rg[a/4]} : 32'h0);
    if (!mapd(a)) e = 32'h0;
    axr(a);
    chk("rresp", mapd(a) ? 2'b00 : 2'b10, rsp);
    chk("rdata", e, rdv);
  endtask : rd

  task automatic apply(input logic [55:0] r, input bit i, input bit x, input bit ce);
    logic [15:0] v;
    @(posedge mclk);
    reqBus <= r;
    iCmd <= i;
    xCmd <= x;
    clkEn <= ce;
    @(posedge mclk);
    clkEn <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    v = exp_vec();
    chk("vectorAddr", v, vectorAddr);
    chk("vectorValid", v != 16'h0, vectorValid);
    if (v != 16'h0) chk("takenVec", v, takenVec);
  endtask : apply

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // Whole run needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    end_of_test();
  end

  // ======
  // Tests
  initial begin
    {reset, clkEn, normalMode, iCmd, xCmd} = 5'h1F;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, reqBus} = '0;
    s_wstrb = 4'hF;
    seed = 32'hb95a;
    n_errors = 0;
    n_checks = 0;
    shadow_reset();
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      rd(8'(i * 4));
    end
    rd(8'h34);
    rd(8'h02);
    wr(8'h34, 32'h5A);
    $display("test start values done");
    wr(8'h1C, 32'h55);
    wr(8'h1C, 32'hAA);
    rd(8'h1C);
    chk("eepromMap", 8'h55, eepromMap);
    normalMode <= 1'b0;
    wr(8'h20, 32'hC3);
    normalMode <= 1'b1;
    wr(8'h20, 32'h3C);
    rd(8'h20);
    chk("progPage", 8'h3C, progPage);
    $display("test map and page done");
    for (int s = 0; s < 5; s++) begin
      for (int on = 0; on < 2; on++) begin
        wr(8'(SR[s] * 4), 32'(on << SB[s]));
        @(negedge mclk);
        if (s == 0) chk("clkMonArmed", on, clkMonArmed);
        apply(56'h1 << SL[s], 1'b0, 1'b1, 1'b1);
        apply(56'h1 << SL[s], 1'b1, 1'b1, 1'b1);
      end
    end
    $display("test gated sources done");
    wr(8'h08, 32'hFF);
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 32'(8'hEE - 2 * c));
      apply(56'h0000_0400_FF40, 1'b0, 1'b1, 1'b1);
    end
    $display("test channel elevation done");
    for (int n = 0; n < 80; n++) begin
      wr(8'(WREG[rnd() % 9] * 4), rnd());
      rq = 56'({rnd(), rnd()} & {rnd(), rnd()} & {rnd(), rnd()});
      if (rnd() % 4 != 0) rq[5:0] = 6'h00;
      seed = rnd();
      apply(rq, seed[0], seed[1], seed[2]);
      rd(8'h28);
    end
    $display("test random requests done");
    apply(56'h1, 1'b0, 1'b0, 1'b1);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("vectorValid", 1'b0, vectorValid);
    chk("eepromMap", 8'h01, eepromMap);
    chk("progPage", 8'h00, progPage);
    reset <= 1'b0;
    shadow_reset();
    rd(8'h04);
    wr(8'h1C, 32'h77);
    normalMode <= 1'b0;
    wr(8'h1C, 32'h66);
    normalMode <= 1'b1;
    rd(8'h1C);
    apply(56'h1, 1'b0, 1'b0, 1'b1);
    $display("test second reset done");
    end_of_test();
  end
endmodule : ivp_top_tb

bind ivp_top ivp_chk #(.REQ_W(REQ_W)) ivp_chk_i (.mclk(mclk), .reset(reset), .clkEn(clkEn), .reqBus(reqBus),
  .ccrIMask(ccrIMask), .ccrXMask(ccrXMask), .normalMode(normalMode), .vectorValid(vectorValid),
  .vectorAddr(vectorAddr), .eepromMap(eepromMap), .progPage(progPage), .s_bresp(s_bresp), .s_bvalid(s_bvalid));
